// ==== hdl/rtcg_consts.svh ====
`ifndef RTCG_CONSTS_SVH
`define RTCG_CONSTS_SVH
`define RTCG_SLAVE_ADDR 7'h68
`define RTCG_LOC_COUNT 64
`define RTCG_LAST_CLOCK_LOC 6'h07
`define RTCG_PTR_RESET 6'h00
`define RTCG_TREC_US 200
`define RTCG_CLK_MHZ 125
`define RTCG_TREC_CYCLES (`RTCG_TREC_US * `RTCG_CLK_MHZ)
`define RTCG_HALF_BIT 8'h9C
`endif

// ==== hdl/rtcg_pkg.sv ====
`default_nettype none
package rtcg_pkg;
  typedef enum logic [2:0] {
    RTCG_S_IDLE, RTCG_S_ADDR, RTCG_S_ACK, RTCG_S_RX, RTCG_S_TX, RTCG_S_MACK, RTCG_S_IGNORE
  } rtcg_slv_state_e;
  typedef enum logic [2:0] {
    RTCG_M_IDLE, RTCG_M_START, RTCG_M_BIT, RTCG_M_ACKB, RTCG_M_STOP, RTCG_M_DONE
  } rtcg_mst_state_e;
  typedef logic [5:0] rtcg_ptr_t;
  typedef logic [7:0] rtcg_byte_t;
endpackage : rtcg_pkg
`default_nettype wire

// ==== hdl/rtcg_bus_if.sv ====
`default_nettype none
interface rtcg_bus_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe, input scl,
    input sda);
  modport slave (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface : rtcg_bus_if
`default_nettype wire

// ==== hdl/rtcg_line_sync.sv ====
`default_nettype none
module rtcg_line_sync
  import rtcg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic line_in,
  output logic line_out
);
  logic stage1;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1 <= 1'b1;
      line_out <= 1'b1;
    end else if (ce) begin
      stage1 <= line_in;
      line_out <= stage1;
    end
  end
endmodule : rtcg_line_sync
`default_nettype wire

// ==== hdl/rtcg_slave.sv ====
// What this block does
// [RULE1] Respond only after START plus fixed address.
// [RULE2] Sixty-four byte locations in pointer order.
// [RULE3] Power fail aborts, clears pointer, ignores bus.
// [RULE4] Transfers start only from idle bus.
// [RULE5] SDA falling while SCL high is START.
// [RULE6] SDA rising while SCL high is STOP.
// [RULE7] One SCL pulse per bit, sampled high.
// [RULE8] Eight bits then one acknowledge bit.
// [RULE9] Acknowledger holds SDA low through clock high.
// [RULE10] Master withholds acknowledge after last read.
// [RULE11] Release SDA after transmitted byte not acknowledged.
// [RULE12] Pointer-set read: write address, restart, read.
// [RULE13] Pointer increments only on data acknowledge clock.
// [RULE14] Keep sending successive bytes while acknowledged.
// [RULE15] Freeze clock copy while pointer in clock range.
// [RULE16] Plain read starts at current pointer.
// [RULE17] Write: word address loads pointer, then data.
// [RULE18] Acknowledge address, word address, every data byte.
// [RULE19] Power fail blocks access, asserts reset output.
// [RULE20] Out of tolerance forces SRAM select high.
// [RULE21] Below switchover, all outputs high impedance.
// [RULE22] Recovery interval keeps select inhibited, reset active.
// [RULE23] SRAM select output gates the select input.
// [RULE24] Pointer wraps from last location to zero.
`default_nettype none
`include "rtcg_consts.svh"
module rtcg_slave
  import rtcg_pkg::*;
#(
  parameter int TREC_CYCLES = `RTCG_TREC_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  rtcg_bus_if.slave bus,
  input wire logic supply_ok,
  input wire logic above_switchover,
  input wire logic ext_sram_select_in,
  output logic gated_sram_select_out,
  output logic sram_select_oe,
  output logic reset_out_n,
  output logic reset_out_oe,
  output logic clock_copy_hold,
  output logic wr_strobe,
  output var rtcg_ptr_t word_pointer_value,
  output var rtcg_byte_t wr_data,
  input wire rtcg_byte_t rd_data
);
  logic scl_s;
  logic sda_s;
  logic scl_d;
  logic sda_d;
  logic pf_s;
  logic so_s;
  logic sel_s;
  logic access_ok;
  logic [31:0] trec_cnt;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  rtcg_slv_state_e state;
  logic [3:0] bit_cnt;
  rtcg_byte_t shreg;
  logic is_read;
  logic addr_phase;
  logic first_data;
  logic sda_drive_low;
  logic sda_oe_q;

  rtcg_line_sync u_scl (.clk_sys(clk_sys), .rst(rst), .ce(ce), .line_in(bus.scl),
    .line_out(scl_s));
  rtcg_line_sync u_sda (.clk_sys(clk_sys), .rst(rst), .ce(ce), .line_in(bus.sda),
    .line_out(sda_s));
  rtcg_line_sync u_pf (.clk_sys(clk_sys), .rst(rst), .ce(ce), .line_in(supply_ok),
    .line_out(pf_s));
  rtcg_line_sync u_so (.clk_sys(clk_sys), .rst(rst), .ce(ce), .line_in(above_switchover),
    .line_out(so_s));
  rtcg_line_sync u_sel (.clk_sys(clk_sys), .rst(rst), .ce(ce), .line_in(ext_sram_select_in),
    .line_out(sel_s));

  assign start_det = scl_s && scl_d && sda_d && !sda_s; // [RULE5]
  assign stop_det = scl_s && scl_d && !sda_d && sda_s; // [RULE6]
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (ce) begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Recovery counter holds access off after supply returns.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trec_cnt <= 32'h0000_0000;
      access_ok <= 1'b0;
    end else if (ce) begin
      if (!pf_s) begin
        trec_cnt <= 32'h0000_0000; // [RULE19]
        access_ok <= 1'b0; // [RULE19]
      end else if (trec_cnt < TREC_CYCLES) begin
        trec_cnt <= trec_cnt + 32'h0000_0001; // [RULE22]
      end else begin
        access_ok <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gated_sram_select_out <= 1'b1;
      sram_select_oe <= 1'b0;
      reset_out_n <= 1'b0;
      reset_out_oe <= 1'b0;
    end else if (ce) begin
      gated_sram_select_out <= access_ok ? sel_s : 1'b1; // [RULE20] [RULE23] [RULE22]
      reset_out_n <= 1'b0;
      reset_out_oe <= so_s && !access_ok; // [RULE19] [RULE21]
      sram_select_oe <= so_s; // [RULE21]
    end
  end

  // Bus protocol engine.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= RTCG_S_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      is_read <= 1'b0;
      addr_phase <= 1'b0;
      first_data <= 1'b0;
      sda_drive_low <= 1'b0;
      word_pointer_value <= `RTCG_PTR_RESET;
      wr_strobe <= 1'b0;
      wr_data <= 8'h00;
    end else if (ce) begin
      wr_strobe <= 1'b0;
      if (!access_ok) begin
        state <= RTCG_S_IDLE; // [RULE3]
        word_pointer_value <= `RTCG_PTR_RESET; // [RULE3]
        sda_drive_low <= 1'b0; // [RULE3]
      end else if (start_det) begin
        state <= RTCG_S_ADDR; // [RULE1] [RULE4]
        bit_cnt <= 4'h0;
        addr_phase <= 1'b1;
        sda_drive_low <= 1'b0;
      end else if (stop_det) begin
        state <= RTCG_S_IDLE; // [RULE6]
        sda_drive_low <= 1'b0;
      end else begin
        case (state)
          RTCG_S_IDLE, RTCG_S_IGNORE: begin
            sda_drive_low <= 1'b0;
          end
          RTCG_S_ADDR, RTCG_S_RX: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s}; // [RULE7]
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0; // [RULE8]
              if (state == RTCG_S_ADDR) begin
                if (shreg[7:1] == `RTCG_SLAVE_ADDR) begin
                  is_read <= shreg[0];
                  first_data <= 1'b1;
                  sda_drive_low <= 1'b1; // [RULE1] [RULE18]
                  state <= RTCG_S_ACK;
                end else begin
                  state <= RTCG_S_IGNORE; // [RULE1]
                end
              end else begin
                sda_drive_low <= 1'b1; // [RULE18] [RULE9]
                state <= RTCG_S_ACK;
                if (first_data) begin
                  word_pointer_value <= shreg[5:0]; // [RULE17] [RULE12] [RULE2]
                end else begin
                  wr_data <= shreg; // [RULE17]
                  wr_strobe <= 1'b1;
                end
              end
            end
          end
          RTCG_S_ACK: begin
            // The word address byte keeps first_data set here, so only data bytes step.
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (!addr_phase && !first_data && !is_read) begin
                word_pointer_value <= word_pointer_value + 6'h01; // [RULE13] [RULE24]
              end
              if (is_read && addr_phase) begin
                shreg <= rd_data; // [RULE16]
                sda_drive_low <= !rd_data[7];
                state <= RTCG_S_TX;
              end else begin
                sda_drive_low <= 1'b0;
                state <= RTCG_S_RX;
              end
              first_data <= first_data && addr_phase && !is_read;
              addr_phase <= 1'b0;
            end
          end
          RTCG_S_TX: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h7) begin
                sda_drive_low <= 1'b0;
                state <= RTCG_S_MACK;
              end else begin
                sda_drive_low <= !shreg[6];
                shreg <= {shreg[6:0], 1'b0};
              end
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          RTCG_S_MACK: begin
            if (scl_rise) begin
              word_pointer_value <= word_pointer_value + 6'h01; // [RULE13] [RULE24]
              is_read <= !sda_s; // [RULE10]
            end else if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (is_read) begin
                shreg <= rd_data; // [RULE14]
                sda_drive_low <= !rd_data[7];
                state <= RTCG_S_TX;
              end else begin
                state <= RTCG_S_IGNORE; // [RULE11]
              end
            end
          end
          default: state <= RTCG_S_IDLE;
        endcase
      end
    end
  end

  // Copy from the running clock is held while a clock location is addressed in a transfer.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clock_copy_hold <= 1'b0;
    end else if (ce) begin
      clock_copy_hold <= (state != RTCG_S_IDLE) && (state != RTCG_S_IGNORE) && !stop_det &&
        (word_pointer_value <= `RTCG_LAST_CLOCK_LOC); // [RULE15]
    end
  end

  // Data line enable is registered so the pin comes straight from a flip-flop.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sda_oe_q <= 1'b0;
    end else if (ce) begin
      sda_oe_q <= sda_drive_low && so_s; // [RULE9] [RULE21]
    end
  end

  assign bus.sda_s_o = 1'b0;
  assign bus.sda_s_oe = sda_oe_q;
endmodule : rtcg_slave
`default_nettype wire

// ==== hdl/rtcg_master.sv ====
`default_nettype none
`include "rtcg_consts.svh"
module rtcg_master
  import rtcg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  rtcg_bus_if.master bus,
  input wire logic cmd_valid,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic cmd_read,
  input wire logic cmd_last,
  input wire rtcg_byte_t cmd_data,
  output logic busy,
  output logic done,
  output logic nacked,
  output var rtcg_byte_t rx_data
);
  rtcg_mst_state_e state;
  logic [7:0] tick;
  logic phase;
  logic [3:0] bit_cnt;
  rtcg_byte_t shreg;
  logic rd;
  logic last;
  logic stp;
  logic scl_low;
  logic sda_low;
  logic sda_s;

  rtcg_line_sync u_sda (.clk_sys(clk_sys), .rst(rst), .ce(ce), .line_in(bus.sda),
    .line_out(sda_s));

  // Each bus phase lasts one half bit; outside START, phase 0 holds SCL low and phase 1 releases it; START keeps SCL released in both.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= RTCG_M_IDLE;
      tick <= 8'h00;
      phase <= 1'b0;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      rd <= 1'b0;
      last <= 1'b0;
      stp <= 1'b0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      nacked <= 1'b0;
      rx_data <= 8'h00;
    end else if (ce) begin
      done <= 1'b0;
      if (state != RTCG_M_IDLE) begin
        tick <= (tick == `RTCG_HALF_BIT) ? 8'h00 : tick + 8'h01;
      end
      case (state)
        RTCG_M_IDLE: begin
          if (cmd_valid) begin
            busy <= 1'b1;
            shreg <= cmd_data;
            rd <= cmd_read;
            last <= cmd_last;
            stp <= cmd_stop;
            bit_cnt <= 4'h0;
            phase <= 1'b0;
            tick <= 8'h00;
            state <= cmd_start ? RTCG_M_START : RTCG_M_BIT;
            if (cmd_start) begin
              sda_low <= 1'b0; // [RULE4]
              scl_low <= 1'b0;
            end
          end
        end
        RTCG_M_START: begin
          if (tick == `RTCG_HALF_BIT) begin
            if (!phase) begin
              sda_low <= 1'b1; // [RULE5]
              phase <= 1'b1;
            end else begin
              scl_low <= 1'b1;
              phase <= 1'b0;
              state <= RTCG_M_BIT;
            end
          end
        end
        RTCG_M_BIT: begin
          // Data moves one cycle after the clock falls, never as it rises.
          if (!phase && tick == 8'h00) begin
            sda_low <= rd ? 1'b0 : !shreg[7]; // [RULE7]
          end
          if (tick == `RTCG_HALF_BIT) begin
            if (!phase) begin
              scl_low <= 1'b0;
              phase <= 1'b1;
            end else begin
              scl_low <= 1'b1;
              shreg <= {shreg[6:0], sda_s};
              phase <= 1'b0;
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'h7) begin
                state <= RTCG_M_ACKB; // [RULE8]
              end
            end
          end
        end
        RTCG_M_ACKB: begin
          if (!phase && tick == 8'h00) begin
            sda_low <= rd && !last; // [RULE9] [RULE10]
          end
          if (tick == `RTCG_HALF_BIT) begin
            if (!phase) begin
              scl_low <= 1'b0;
              phase <= 1'b1;
            end else begin
              if (!rd) begin
                nacked <= sda_s;
              end
              rx_data <= shreg;
              scl_low <= 1'b1;
              phase <= 1'b0;
              state <= stp ? RTCG_M_STOP : RTCG_M_DONE;
            end
          end
        end
        RTCG_M_STOP: begin
          if (!phase && tick == 8'h00) begin
            sda_low <= 1'b1;
          end
          if (tick == `RTCG_HALF_BIT) begin
            if (!phase) begin
              scl_low <= 1'b0;
              phase <= 1'b1;
            end else begin
              sda_low <= 1'b0; // [RULE6]
              state <= RTCG_M_DONE;
            end
          end
        end
        RTCG_M_DONE: begin
          busy <= 1'b0;
          done <= 1'b1;
          state <= RTCG_M_IDLE;
        end
        default: state <= RTCG_M_IDLE;
      endcase
    end
  end

  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = scl_low;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe = sda_low;
endmodule : rtcg_master
`default_nettype wire

// ==== dv/rtcg_slave_properties.sv ====
`default_nettype none
module rtcg_slave_properties
  import rtcg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_s_oe,
  input wire logic supply_ok,
  input wire logic above_switchover,
  input wire logic ext_sram_select_in,
  input wire logic gated_sram_select_out,
  input wire logic sram_select_oe,
  input wire logic reset_out_oe,
  input wire logic clock_copy_hold,
  input wire logic wr_strobe,
  input wire rtcg_ptr_t word_pointer_value
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  chk_drive_clock_low: assert property ($rose(sda_s_oe) |-> !scl)
    else $error("slave began driving data while clock high");
  chk_ack_release_low: assert property ($fell(sda_s_oe) && supply_ok |-> !scl)
    else $error("slave released data while clock high");
  chk_bus_ignored: assert property (!supply_ok [*8] |-> !sda_s_oe)
    else $error("slave drove data during power fail");
  chk_select_forced: assert property (!supply_ok [*8] |-> gated_sram_select_out)
    else $error("sram select not forced inactive");
  chk_reset_driven: assert property (
    (!supply_ok && above_switchover) [*8] |-> reset_out_oe)
    else $error("reset output not active during power fail");
  chk_outputs_float: assert property (
    !above_switchover [*8] |-> !sram_select_oe && !reset_out_oe && !sda_s_oe)
    else $error("outputs driven below switchover");
  chk_recovery_hold: assert property (
    $rose(supply_ok) && above_switchover |-> (reset_out_oe && gated_sram_select_out) [*8])
    else $error("recovery interval cut short");
  chk_hold_clock_range: assert property (
    wr_strobe && word_pointer_value <= 6'h07 |-> clock_copy_hold)
    else $error("clock copy not held for clock location write");
  chk_strobe_single: assert property (wr_strobe |=> !wr_strobe)
    else $error("write strobe longer than one cycle");
  chk_select_follows: assert property (
    (supply_ok && !reset_out_oe && above_switchover && $stable(ext_sram_select_in)) [*5]
    |-> gated_sram_select_out == ext_sram_select_in)
    else $error("sram select output does not follow input");
endmodule : rtcg_slave_properties
`default_nettype wire

// ==== dv/rtcg_i2c_slave_powerfail_gate_tb_top.sv ====
`default_nettype none
module rtcg_i2c_slave_powerfail_gate_tb_top
  import rtcg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] F_S = 4'h8;
  localparam logic [3:0] F_P = 4'h4;
  localparam logic [3:0] F_RD = 4'h2;
  localparam logic [3:0] F_END = 4'h7;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic supply_ok = 1'b1;
  logic above_switchover = 1'b1;
  logic ext_sram_select_in = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_start = 1'b0;
  logic cmd_stop = 1'b0;
  logic cmd_read = 1'b0;
  logic cmd_last = 1'b0;
  rtcg_byte_t cmd_data = 8'h00;
  logic gated_sram_select_out, sram_select_oe, reset_out_n, reset_out_oe;
  logic clock_copy_hold, wr_strobe, busy, done, nacked;
  rtcg_ptr_t word_pointer_value;
  rtcg_byte_t wr_data, rx_data;
  rtcg_byte_t mem [64];
  int n_errors = 0;
  int num_checks = 0;
  rtcg_bus_if bus ();
  assign bus.scl = ~bus.scl_oe;
  assign bus.sda = ~(bus.sda_m_oe | bus.sda_s_oe);
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (wr_strobe === 1'b1) begin
      mem[word_pointer_value] <= wr_data;
    end
  end
  rtcg_slave #(.TREC_CYCLES(20)) u_rtcg_slave (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
    .bus(bus), .supply_ok(supply_ok), .above_switchover(above_switchover),
    .ext_sram_select_in(ext_sram_select_in), .gated_sram_select_out(gated_sram_select_out),
    .sram_select_oe(sram_select_oe), .reset_out_n(reset_out_n), .reset_out_oe(reset_out_oe),
    .clock_copy_hold(clock_copy_hold), .wr_strobe(wr_strobe),
    .word_pointer_value(word_pointer_value), .wr_data(wr_data),
    .rd_data(mem[word_pointer_value]));
  rtcg_master u_rtcg_master (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .bus(bus),
    .cmd_valid(cmd_valid), .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read),
    .cmd_last(cmd_last), .cmd_data(cmd_data), .busy(busy), .done(done), .nacked(nacked),
    .rx_data(rx_data));
  rtcg_slave_properties u_rtcg_slave_properties (.clk_sys(clk_sys), .rst(rst),
    .scl(bus.scl), .sda_s_oe(bus.sda_s_oe), .supply_ok(supply_ok),
    .above_switchover(above_switchover), .ext_sram_select_in(ext_sram_select_in),
    .gated_sram_select_out(gated_sram_select_out), .sram_select_oe(sram_select_oe),
    .reset_out_oe(reset_out_oe), .clock_copy_hold(clock_copy_hold), .wr_strobe(wr_strobe),
    .word_pointer_value(word_pointer_value));
  task automatic chk(input string nm, input rtcg_byte_t seen, input rtcg_byte_t exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  // One byte command: start, stop, read, last flags then the byte.
  task automatic xfer(input logic [3:0] f, input rtcg_byte_t d);
    int n;
    @(negedge clk_sys);
    {cmd_start, cmd_stop, cmd_read, cmd_last} = f;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 6000) begin
      @(negedge clk_sys);
      n++;
    end
    chk("done", n < 6000, 8'h01);
    chk("busy", busy, 8'h00);
    repeat (4) @(negedge clk_sys);
  endtask : xfer
  task automatic s_write();
    xfer(F_S, 8'hD0);
    chk("addr ack", nacked, 8'h00);
    xfer(4'h0, 8'h3E);
    chk("word ack", nacked, 8'h00);
    xfer(4'h0, 8'hA5);
    xfer(4'h0, 8'h5A);
    chk("data ack", nacked, 8'h00);
    xfer(F_P, 8'hC3);
    chk("mem 3e", mem[6'h3E], 8'hA5);
    chk("mem 3f", mem[6'h3F], 8'h5A);
    chk("mem 00", mem[6'h00], 8'hC3);
    chk("pointer", word_pointer_value, 8'h01);
  endtask : s_write
  task automatic s_alt_read();
    xfer(F_S, 8'hD1);
    xfer(F_END, 8'h00);
    chk("alt read", rx_data, 8'h3C);
    chk("released", bus.sda_s_oe, 8'h00);
  endtask : s_alt_read
  task automatic s_read();
    xfer(F_S, 8'hD0);
    xfer(4'h0, 8'h3E);
    xfer(F_S, 8'hD1);
    xfer(F_RD, 8'h00);
    chk("read 3e", rx_data, 8'hA5);
    xfer(F_RD, 8'h00);
    chk("read 3f", rx_data, 8'h5A);
    xfer(F_END, 8'h00);
    chk("read 00", rx_data, 8'hC3);
    chk("released", bus.sda_s_oe, 8'h00);
  endtask : s_read
  task automatic s_bad_addr();
    xfer(F_S | F_P, 8'hA0);
    chk("other addr", nacked, 8'h01);
  endtask : s_bad_addr
  task automatic s_hold();
    xfer(F_S, 8'hD0);
    xfer(4'h0, 8'h06);
    chk("hold on", clock_copy_hold, 8'h01);
    xfer(4'h0, 8'h11);
    xfer(4'h0, 8'h22);
    chk("hold past", clock_copy_hold, 8'h00);
    xfer(F_P, 8'h33);
    chk("mem 08", mem[6'h08], 8'h33);
    xfer(F_S, 8'hD0);
    xfer(4'h0, 8'h02);
    chk("hold on", clock_copy_hold, 8'h01);
    xfer(F_P, 8'h44);
    chk("hold stop", clock_copy_hold, 8'h00);
  endtask : s_hold
  task automatic s_pfail();
    ext_sram_select_in = 1'b0;
    xfer(F_S, 8'hD0);
    chk("sel pass", gated_sram_select_out, 8'h00);
    xfer(4'h0, 8'h10);
    supply_ok = 1'b0;
    repeat (10) @(negedge clk_sys);
    chk("sel forced", gated_sram_select_out, 8'h01);
    chk("reset on", reset_out_oe, 8'h01);
    chk("reset level", reset_out_n, 8'h00);
    chk("ptr clear", word_pointer_value, 8'h00);
    xfer(F_P, 8'h77);
    chk("ignored", nacked, 8'h01);
    chk("mem 10", mem[6'h10], 8'h00);
    above_switchover = 1'b0;
    repeat (10) @(negedge clk_sys);
    chk("float", {sram_select_oe, reset_out_oe, bus.sda_s_oe}, 8'h00);
    above_switchover = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk("back on", reset_out_oe, 8'h01);
    supply_ok = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk("rec reset", reset_out_oe, 8'h01);
    chk("rec sel", gated_sram_select_out, 8'h01);
    repeat (40) @(negedge clk_sys);
    chk("reset off", reset_out_oe, 8'h00);
    chk("sel back", gated_sram_select_out, 8'h00);
  endtask : s_pfail
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 8'h00;
    end
    mem[1] = 8'h3C;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    repeat (40) @(negedge clk_sys);
    s_write();
    s_alt_read();
    s_read();
    s_bad_addr();
    s_hold();
    s_pfail();
    give_verdict();
  end
  initial begin
    #790000;
    n_errors++;
    give_verdict();
  end
endmodule : rtcg_i2c_slave_powerfail_gate_tb_top
`default_nettype wire
